//--- hw/cvgc_pkg.sv
// Purpose: Constants and types for the per-core video generator block
// Assumes: One system clock, APB register access, video PLL clock sampled as a level
// Notes: Register offsets are byte addresses on the APB word grid
// Contract
// - Colour depth 0 gives 32 one-bit pixels, colour entries 0 and 1 only.
// - Colour depth 1 gives 16 two-bit pixels, colour entries 0 to 3.
// - Broadcast colour enable bit removes or keeps colour on broadcast signal.
// - Baseband colour enable bit removes or keeps colour on baseband signal.
// - Three-bit audio source field picks which core's PLL clock feeds audio.
// - Pin group field picks pins 7..0, 15..8, 23..16 or 31..24; rest reserved.
// - Eight-bit pin mask lets video drive only the masked pins of the group.
// - Clocks-per-pixel sets PLL clocks between successive pixel shifts.
// - Clocks-per-frame sets PLL clocks before each new frame is taken.
// - Pixel and frame counts advance on video PLL clock, never system clock.
// - A frame is a 32-bit colour word and a 32-bit pixel word supplied by the frame wait.
// - Both video registers read back and write like ordinary registers.
// - Each core has its own generator emitting data at a constant rate.
// - Output type 00 off, 01 VGA, 10 and 11 composite nibble orders.
// - Configuration bits: type 30:29, depth 28, chroma 27/26, audio 25:23, group, mask.
package cvgc_pkg;

  // Register byte offsets
  localparam logic [7:0] CVGC_OFS_CONFIG = 8'h00;
  localparam logic [7:0] CVGC_OFS_SCALE = 8'h04;
  localparam logic [7:0] CVGC_OFS_STATUS = 8'h08;

  // Configuration field positions
  localparam int CVGC_CFG_TYPE_HI = 30;
  localparam int CVGC_CFG_TYPE_LO = 29;
  localparam int CVGC_CFG_DEPTH = 28;
  localparam int CVGC_CFG_BCAST_CHROMA = 27;
  localparam int CVGC_CFG_BBAND_CHROMA = 26;
  localparam int CVGC_CFG_AUDIO_HI = 25;
  localparam int CVGC_CFG_AUDIO_LO = 23;
  localparam int CVGC_CFG_GROUP_HI = 11;
  localparam int CVGC_CFG_GROUP_LO = 9;
  localparam int CVGC_CFG_MASK_HI = 7;
  localparam int CVGC_CFG_MASK_LO = 0;
  localparam logic [31:0] CVGC_CFG_WMASK = 32'h7f800eff;

  // Scale field positions
  localparam int CVGC_SCL_PIX_HI = 19;
  localparam int CVGC_SCL_PIX_LO = 12;
  localparam int CVGC_SCL_FRM_HI = 11;
  localparam int CVGC_SCL_FRM_LO = 0;
  localparam logic [31:0] CVGC_SCL_WMASK = 32'h000fffff;

  // Status field positions
  localparam int CVGC_STS_UNDERRUN = 8;
  localparam int CVGC_STS_LEVEL_HI = 1;
  localparam int CVGC_STS_LEVEL_LO = 0;

  // Reset values
  localparam logic [31:0] CVGC_CONFIG_RST = 32'h00000000;
  localparam logic [31:0] CVGC_SCALE_RST = 32'h00000000;

  // Buffer depth and last pin group code
  localparam logic [1:0] CVGC_FIFO_DEPTH = 2'h2;
  localparam logic [2:0] CVGC_GROUP_LAST = 3'h3;
  localparam logic [7:0] CVGC_PIX_ONE = 8'h01;
  localparam logic [11:0] CVGC_FRM_ONE = 12'h001;

  // Output types
  typedef enum logic [1:0] {
    CVGC_OUT_OFF = 2'b00,
    CVGC_OUT_VGA = 2'b01,
    CVGC_OUT_COMP1 = 2'b10,
    CVGC_OUT_COMP2 = 2'b11
  } cvgc_out_type_t;

  // One frame handed over by the frame wait
  typedef struct packed {
    logic [31:0] colours;
    logic [31:0] pixels;
  } cvgc_frame_t;

  // APB request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } cvgc_apb_req_t;

endpackage : cvgc_pkg

//--- hw/cvgc_top.sv
// Purpose: Per-core video generator with configuration and scale registers
// Assumes: All inputs synchronous to clock_in; video PLL clock slower than half clock_in
// Notes: Frames queue in a two-entry buffer; an empty buffer at expiry keeps the shifter and colours and flags underrun
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module cvgc_top (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // APB slave
  input wire cvgc_pkg::cvgc_apb_req_t apb_in,
  output logic pready_out,
  output logic [31:0] prdata_out,
  output logic pslverr_out,
  // Video PLL clocks, own and of every core
  input wire logic video_pll_clock_in,
  input wire logic [7:0] all_core_pll_in,
  // Frame wait from the core
  input wire logic frame_valid_in,
  input wire cvgc_pkg::cvgc_frame_t frame_in,
  output logic frame_ready_out,
  // Video pins and audio carrier
  output logic [31:0] video_pins_out,
  output logic [31:0] video_pins_oe_out,
  output logic audio_subcarrier_out
);
  import cvgc_pkg::*;

  // Register state
  logic [31:0] config_q, config_d;
  logic [31:0] scale_q, scale_d;
  logic underrun_q, underrun_d;
  logic [31:0] rdata_q, rdata_d;

  // Buffer state
  cvgc_frame_t fifo_mem_q [2];
  cvgc_frame_t fifo_mem_d [2];
  logic wr_ptr_q, wr_ptr_d;
  logic rd_ptr_q, rd_ptr_d;
  logic [1:0] level_q, level_d;

  // Generator state
  logic pll_prev_q, pll_prev_d;
  logic [7:0] pix_cnt_q, pix_cnt_d;
  logic [11:0] frm_cnt_q, frm_cnt_d;
  logic [31:0] shift_q, shift_d;
  logic [31:0] colours_q, colours_d;
  logic [31:0] pins_q, pins_d;
  logic [31:0] oe_q, oe_d;
  logic audio_q, audio_d;

  // Decoded fields
  cvgc_out_type_t out_type;
  logic depth_sel;
  logic bcast_chroma;
  logic bband_chroma;
  logic [2:0] audio_sel;
  logic [2:0] group_sel;
  logic [7:0] pin_mask;
  logic [7:0] pix_clocks;
  logic [11:0] frm_clocks;

  // Handshake terms
  logic wr_en, rd_setup, addr_hit;
  logic push, pop, fifo_valid, pll_tick, frame_end;

  // Field decode
  always_comb begin
    out_type = cvgc_out_type_t'(config_q[CVGC_CFG_TYPE_HI:CVGC_CFG_TYPE_LO]);
    depth_sel = config_q[CVGC_CFG_DEPTH];
    bcast_chroma = config_q[CVGC_CFG_BCAST_CHROMA];
    bband_chroma = config_q[CVGC_CFG_BBAND_CHROMA];
    audio_sel = config_q[CVGC_CFG_AUDIO_HI:CVGC_CFG_AUDIO_LO];
    group_sel = config_q[CVGC_CFG_GROUP_HI:CVGC_CFG_GROUP_LO];
    pin_mask = config_q[CVGC_CFG_MASK_HI:CVGC_CFG_MASK_LO];
    pix_clocks = scale_q[CVGC_SCL_PIX_HI:CVGC_SCL_PIX_LO];
    frm_clocks = scale_q[CVGC_SCL_FRM_HI:CVGC_SCL_FRM_LO];
  end

  // APB decode; every access finishes in its first access cycle
  assign addr_hit = (apb_in.paddr == CVGC_OFS_CONFIG) || (apb_in.paddr == CVGC_OFS_SCALE) ||
                    (apb_in.paddr == CVGC_OFS_STATUS);
  assign wr_en = apb_in.psel && apb_in.penable && apb_in.pwrite;
  assign rd_setup = apb_in.psel && !apb_in.penable;
  assign pready_out = 1'b1;
  assign pslverr_out = apb_in.psel && apb_in.penable && !addr_hit;
  assign prdata_out = rdata_q;

  // Register next values; read data is latched in setup so it comes from a flop
  always_comb begin
    config_d = config_q;
    scale_d = scale_q;
    underrun_d = underrun_q;
    rdata_d = rdata_q;
    if (wr_en && apb_in.paddr == CVGC_OFS_CONFIG) begin
      config_d = apb_in.pwdata & CVGC_CFG_WMASK;
    end
    if (wr_en && apb_in.paddr == CVGC_OFS_SCALE) begin
      scale_d = apb_in.pwdata & CVGC_SCL_WMASK;
    end
    if (wr_en && apb_in.paddr == CVGC_OFS_STATUS && apb_in.pwdata[CVGC_STS_UNDERRUN]) begin
      underrun_d = 1'b0;
    end
    // A new underrun in the clearing cycle wins over the clear
    if (frame_end && !fifo_valid) begin
      underrun_d = 1'b1;
    end
    if (rd_setup) begin
      case (apb_in.paddr)
        CVGC_OFS_CONFIG: rdata_d = config_q;
        CVGC_OFS_SCALE: rdata_d = scale_q;
        CVGC_OFS_STATUS: begin
          rdata_d = 32'h00000000;
          rdata_d[CVGC_STS_UNDERRUN] = underrun_q;
          rdata_d[CVGC_STS_LEVEL_HI:CVGC_STS_LEVEL_LO] = level_q;
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      config_q <= CVGC_CONFIG_RST;
      scale_q <= CVGC_SCALE_RST;
      underrun_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      config_q <= config_d;
      scale_q <= scale_d;
      underrun_q <= underrun_d;
      rdata_q <= rdata_d;
    end
  end

  // Two-entry frame buffer; a full buffer holds the core in its frame wait
  assign fifo_valid = (level_q != 2'h0);
  assign frame_ready_out = (level_q != CVGC_FIFO_DEPTH);
  assign push = frame_valid_in && frame_ready_out;
  assign pop = frame_end && fifo_valid;

  always_comb begin
    fifo_mem_d = fifo_mem_q;
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    level_d = level_q;
    if (push) begin
      fifo_mem_d[wr_ptr_q] = frame_in;
      wr_ptr_d = !wr_ptr_q;
    end
    if (pop) begin
      rd_ptr_d = !rd_ptr_q;
    end
    case ({push, pop})
      2'b10: level_d = level_q + 2'h1;
      2'b01: level_d = level_q - 2'h1;
      default: level_d = level_q;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fifo_mem_q[0] <= '0;
      fifo_mem_q[1] <= '0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      level_q <= 2'h0;
    end else begin
      fifo_mem_q <= fifo_mem_d;
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      level_q <= level_d;
    end
  end

  // Rising edge of this core's video PLL clock is the only counting event
  assign pll_tick = video_pll_clock_in && !pll_prev_q;
  assign frame_end = pll_tick && (out_type != CVGC_OUT_OFF) && (frm_cnt_q == 12'h000);

  // Pixel and frame counters, shifter and pin drive
  always_comb begin
    logic [1:0] pix_idx;
    logic [7:0] colour;
    logic [3:0] bcast_nib, bband_nib;
    logic [7:0] pin_byte;
    pix_idx = 2'h0;
    colour = 8'h00;
    bcast_nib = 4'h0;
    bband_nib = 4'h0;
    pin_byte = 8'h00;
    pll_prev_d = video_pll_clock_in;
    pix_cnt_d = pix_cnt_q;
    frm_cnt_d = frm_cnt_q;
    shift_d = shift_q;
    colours_d = colours_q;
    if (out_type == CVGC_OUT_OFF) begin
      // Zeroed counters make the first tick after enabling fetch a frame
      pix_cnt_d = 8'h00;
      frm_cnt_d = 12'h000;
    end else if (pll_tick) begin
      if (frm_cnt_q == 12'h000) begin
        frm_cnt_d = frm_clocks - CVGC_FRM_ONE;
        pix_cnt_d = pix_clocks - CVGC_PIX_ONE;
        if (fifo_valid) begin
          shift_d = fifo_mem_q[rd_ptr_q].pixels;
          colours_d = fifo_mem_q[rd_ptr_q].colours;
        end
      end else begin
        frm_cnt_d = frm_cnt_q - CVGC_FRM_ONE;
        if (pix_cnt_q == 8'h00) begin
          pix_cnt_d = pix_clocks - CVGC_PIX_ONE;
          shift_d = depth_sel ? {2'b00, shift_q[31:2]} : {1'b0, shift_q[31:1]};
        end else begin
          pix_cnt_d = pix_cnt_q - CVGC_PIX_ONE;
        end
      end
    end
    // Current pixel picks one colour byte
    pix_idx = depth_sel ? shift_q[1:0] : {1'b0, shift_q[0]};
    colour = colours_q[{pix_idx, 3'b000} +: 8];
    // Colour removal clears the chroma bit of each composite nibble
    bcast_nib = {colour[7] & bcast_chroma, colour[6:4]};
    bband_nib = {colour[3] & bband_chroma, colour[2:0]};
    case (out_type)
      CVGC_OUT_VGA: pin_byte = colour;
      CVGC_OUT_COMP1: pin_byte = {bcast_nib, bband_nib};
      CVGC_OUT_COMP2: pin_byte = {bband_nib, bcast_nib};
      default: pin_byte = 8'h00;
    endcase
    pins_d = 32'h00000000;
    oe_d = 32'h00000000;
    // Reserved group codes drive nothing
    if (out_type != CVGC_OUT_OFF && group_sel <= CVGC_GROUP_LAST) begin
      pins_d[{group_sel[1:0], 3'b000} +: 8] = pin_byte & pin_mask;
      oe_d[{group_sel[1:0], 3'b000} +: 8] = pin_mask;
    end
    audio_d = all_core_pll_in[audio_sel];
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pll_prev_q <= 1'b0;
      pix_cnt_q <= 8'h00;
      frm_cnt_q <= 12'h000;
      shift_q <= 32'h00000000;
      colours_q <= 32'h00000000;
      pins_q <= 32'h00000000;
      oe_q <= 32'h00000000;
      audio_q <= 1'b0;
    end else begin
      pll_prev_q <= pll_prev_d;
      pix_cnt_q <= pix_cnt_d;
      frm_cnt_q <= frm_cnt_d;
      shift_q <= shift_d;
      colours_q <= colours_d;
      pins_q <= pins_d;
      oe_q <= oe_d;
      audio_q <= audio_d;
    end
  end

  // Registered pin outputs
  assign video_pins_out = pins_q;
  assign video_pins_oe_out = oe_q;
  assign audio_subcarrier_out = audio_q;

endmodule : cvgc_top

//--- tb/cvgc_properties.sv
// Purpose: Port checker for the video generator
// Assumes: One clock domain, reset active low
// Notes: Shadows the configuration register from APB writes
`timescale 1ns/1ps
module cvgc_checker (
  // Clock, reset and bus
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire cvgc_pkg::cvgc_apb_req_t apb_in,
  input wire logic pready_out,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  // Frame port and video side
  input wire logic [7:0] all_core_pll_in,
  input wire logic frame_valid_in,
  input wire logic frame_ready_out,
  input wire logic [31:0] video_pins_out,
  input wire logic [31:0] video_pins_oe_out,
  input wire logic audio_subcarrier_out
);
  import cvgc_pkg::*;
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [31:0] exp_oe;
  logic acc;
  logic unm;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Decode of the access phase
  assign acc = apb_in.psel && apb_in.penable;
  assign unm = !(apb_in.paddr inside {CVGC_OFS_CONFIG, CVGC_OFS_SCALE, CVGC_OFS_STATUS});
  // Shadow of configuration; a second copy so no probe into the design is needed
  always_comb begin
    cfg_d = cfg_q;
    if (acc && apb_in.pwrite && apb_in.paddr == CVGC_OFS_CONFIG) begin
      cfg_d = apb_in.pwdata & CVGC_CFG_WMASK;
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) cfg_q <= CVGC_CONFIG_RST;
    else cfg_q <= cfg_d;
  end
  // Enabled pins; type off and reserved groups drive nothing
  assign exp_oe = (cfg_q[30:29] == 2'b00 || cfg_q[11:9] > CVGC_GROUP_LAST) ? 32'h0 :
                  {24'h0, cfg_q[7:0]} << (8 * cfg_q[11:9]);
  chk_ready_always: assert property (pready_out) else $error("pready low");
  chk_err_unmapped: assert property (pslverr_out == (acc && unm)) else $error("pslverr");
  chk_read_config: assert property (acc && !apb_in.pwrite && apb_in.paddr == CVGC_OFS_CONFIG
    |-> prdata_out == cfg_q) else $error("config read");
  chk_read_unmapped: assert property (acc && !apb_in.pwrite && unm |-> prdata_out == 32'h0)
    else $error("unmapped read");
  chk_pins_masked: assert property ((video_pins_out & ~video_pins_oe_out) == 32'h0)
    else $error("pin without enable");
  chk_group_single: assert property ($onehot0({|video_pins_oe_out[31:24],
    |video_pins_oe_out[23:16], |video_pins_oe_out[15:8], |video_pins_oe_out[7:0]}))
    else $error("two groups");
  chk_oe_config: assert property ($past(rst_n_in, 2) && $stable(cfg_q)
    |-> video_pins_oe_out == exp_oe) else $error("enable vs config");
  chk_ready_falls: assert property ($fell(frame_ready_out)
    |-> $past(frame_valid_in && frame_ready_out)) else $error("ready fell idle");
  chk_audio_select: assert property ($past(rst_n_in, 2)
    |-> audio_subcarrier_out == $past(all_core_pll_in[cfg_q[25:23]])) else $error("audio");
  cov_frame_taken: cover property (frame_valid_in && frame_ready_out);
  cov_buffer_full: cover property (frame_valid_in && !frame_ready_out);
  cov_bad_access: cover property (acc && unm);
endmodule : cvgc_checker
bind cvgc_top cvgc_checker cvgc_checker_i (.clock_in, .rst_n_in, .apb_in, .pready_out,
  .prdata_out, .pslverr_out, .all_core_pll_in, .frame_valid_in, .frame_ready_out,
  .video_pins_out, .video_pins_oe_out, .audio_subcarrier_out);

//--- tb/cvgc_display.sv
// Purpose: Display model watching one eight-pin group
// Assumes: Resistor ladder pulls undriven pins low
// Notes: Combinational; the bench samples it at clock edges
`timescale 1ns/1ps
module cvgc_display (
  // Pins from the generator
  input wire logic [31:0] pins_in,
  input wire logic [31:0] oe_in,
  input wire logic [2:0] group_in,
  // Level seen by the display
  output logic [7:0] seen_out
);
  logic [31:0] lvl;
  // Undriven pins read low, never as the last driven value
  assign lvl = pins_in & oe_in;
  assign seen_out = lvl[8 * group_in[1:0] +: 8];
endmodule : cvgc_display

//--- tb/testbench.sv
// Purpose: Self-checking bench for the video generator
// Assumes: Video clock ticks every 4 system cycles
// Notes: Pixel clocks 2; frame clocks 64 for one-bit and 32 for two-bit pixels keep frames short
`timescale 1ns/1ps
module testbench;
  import cvgc_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic video_pll_clock_in = 1'b0;
  logic frame_valid_in = 1'b0;
  logic [7:0] all_core_pll_in = 8'h00;
  cvgc_apb_req_t apb_in = '0;
  cvgc_frame_t frame_in = '0;
  logic pready_out, pslverr_out, frame_ready_out, audio_subcarrier_out;
  logic [31:0] prdata_out, video_pins_out, video_pins_oe_out, rd, v;
  logic [7:0] seen;
  logic [7:0] a;
  logic [3:0] b, bb;
  logic [1:0] pd = 2'h0;
  int errors = 0;
  int cmp_count = 0;
  int seed = 28745;
  int n, t0;
  cvgc_top cvgc_top_i (.clock_in, .rst_n_in, .apb_in, .pready_out, .prdata_out, .pslverr_out,
    .video_pll_clock_in, .all_core_pll_in, .frame_valid_in, .frame_in, .frame_ready_out,
    .video_pins_out, .video_pins_oe_out, .audio_subcarrier_out);
  cvgc_display cvgc_display_i (.pins_in(video_pins_out), .oe_in(video_pins_oe_out),
    .group_in(3'h1), .seen_out(seen));
  initial begin
    forever #2 clock_in = ~clock_in;
  end
  // Video clock at a quarter of the system rate
  always @(posedge clock_in) begin
    pd <= pd + 2'h1;
    video_pll_clock_in <= pd[1];
  end
  task automatic tally_and_finish(input int hang);
    errors += hang;
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask : check
  // One APB transfer; an idle edge first so psel is never assigned twice at once
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock_in);
    apb_in <= '{1'b1, 1'b0, wr, ad, d};
    @(posedge clock_in);
    apb_in.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) tally_and_finish(1);
    rd = prdata_out;
    apb_in.psel <= 1'b0;
    apb_in.penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] xoe(input logic [31:0] c);
    if (c[30:29] == 2'b00 || c[11:9] > 3'h3) return 32'h0;
    return {24'h0, c[7:0]} << (8 * c[11:9]);
  endfunction : xoe
  // Cycles between two rising edges of ready or of the lowest seen pin
  task automatic rise_gap(input logic sel, input int exp);
    logic p, c;
    int m;
    p = 1'b1;
    m = 0;
    for (int j = 0; j < 2; j++) begin
      t0 = m;
      do begin
        @(posedge clock_in);
        m++;
        c = sel ? frame_ready_out : seen[0];
        if (c === 1'b1 && p === 1'b0) break;
        p = c;
      end while (m < 3000);
      p = c;
    end
    if (m >= 3000) tally_and_finish(1);
    check(m - t0, exp);
  endtask : rise_gap
  initial begin
    repeat (10) @(posedge clock_in);
    rst_n_in <= 1'b1;
    apb(1'b0, CVGC_OFS_SCALE, 32'h0);
    check(rd, CVGC_SCALE_RST);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    // Random words read back through the field masks
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      a = i[0] ? CVGC_OFS_SCALE : CVGC_OFS_CONFIG;
      apb(1'b1, a, v);
      apb(1'b0, a, 32'h0);
      check(rd, v & (i[0] ? CVGC_SCL_WMASK : CVGC_CFG_WMASK));
    end
    // Every group code with every output type
    for (int g = 0; g < 8; g++) begin
      for (int t = 0; t < 4; t++) begin
        v = 32'h0;
        v[30:29] = t[1:0];
        v[11:9] = g[2:0];
        v[7:0] = (t == 1) ? 8'hff : (g[0] ? 8'hf0 : 8'h0f);
        apb(1'b1, CVGC_OFS_CONFIG, v);
        repeat (3) @(posedge clock_in);
        check(video_pins_oe_out, xoe(v));
      end
    end
    // Each core as audio source
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, CVGC_OFS_CONFIG, {6'h0, s[2:0], 23'h0});
      all_core_pll_in <= $random(seed);
      repeat (3) @(posedge clock_in);
      check(audio_subcarrier_out, all_core_pll_in[s]);
    end
    // Fill while video is off: the buffer must refuse a third frame
    apb(1'b1, CVGC_OFS_SCALE, {12'h0, 8'h02, 12'h040});
    frame_in <= '{32'h3cc3a55a, 32'h55555555};
    frame_valid_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    check(frame_ready_out, 1'b0);
    apb(1'b1, CVGC_OFS_CONFIG, 32'h200002ff);
    rise_gap(1'b1, 256);
    rise_gap(1'b0, 16);
    repeat (40) begin
      @(posedge clock_in);
      check(seen === 8'h5a || seen === 8'ha5, 1'b1);
    end
    frame_in <= '{32'h3cc3a55a, 32'hffffffff};
    // Sixteen two-bit pixels fill a frame only with frame clocks at sixteen pixel periods
    apb(1'b1, CVGC_OFS_SCALE, {12'h0, 8'h02, 12'h020});
    apb(1'b1, CVGC_OFS_CONFIG, 32'h300002ff);
    repeat (600) @(posedge clock_in);
    check(seen, 8'h3c);
    // Composite types with each chroma pair
    frame_in <= '{32'hffffffff, 32'h0};
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, CVGC_OFS_CONFIG, {1'b0, 1'b1, k[2], 1'b1, k[1:0], 14'h0, 12'h2ff});
      b = k[1] ? 4'hf : 4'h7;
      bb = k[0] ? 4'hf : 4'h7;
      repeat (600) @(posedge clock_in);
      check(seen, k[2] ? {bb, b} : {b, bb});
    end
    // Core stalls: the buffer drains and offers room again
    frame_valid_in <= 1'b0;
    repeat (900) @(posedge clock_in);
    check(frame_ready_out, 1'b1);
    // Video off so no new expiry re-arms the sticky underrun before the clear is read
    apb(1'b1, CVGC_OFS_CONFIG, 32'h0);
    apb(1'b0, CVGC_OFS_STATUS, 32'h0);
    check(rd, 32'h00000100);
    apb(1'b1, CVGC_OFS_STATUS, 32'h00000100);
    apb(1'b0, CVGC_OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    tally_and_finish(0);
  end
endmodule : testbench
